// ==== mdss_setting_select.sv ====
// Top: source selection, size capture and apply/alarm handling
`timescale 1ns/1ps
`default_nettype none
module mdss_setting_select #(
    parameter int RUN_W = 8
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    // SPI pins
    input  wire logic             spi_sck_i,
    input  wire logic             spi_mosi_i,
    input  wire logic             spi_ss_n_i,
    output logic                  spi_miso_o,
    // Setting pins
    input  wire logic             size_sel_bit0_i,
    input  wire logic             size_sel_bit1_i,
    input  wire logic             size_sel_bit2_i,
    input  wire logic             smooth_drive_input_i,
    input  wire logic             standstill_current_input_i,
    input  wire logic             enable_n_i,
    input  wire logic [RUN_W-1:0] analog_current_input_i,
    // Motor type strap, high for 5-phase
    input  wire logic             five_phase_i,
    // Effective settings
    output logic                  smooth_drive_o,
    output logic                  standstill_half_o,
    output logic                  excite_o,
    output logic [RUN_W-1:0]      operating_current_o,
    output logic [2:0]            size_code_o,
    output logic [11:0]           rated_current_ma_o,
    // State and alarm
    output logic                  operating_o,
    output logic                  cmd_disabled_alarm_o
);

    // Host words carry at most eight bits of operating current
    if (RUN_W < 1 || RUN_W > 8) begin : g_run_w_check
        $error("RUN_W must lie between 1 and 8");
    end

    ////////////////////////////////////////////////////////////////////////

    mdss_word_if wif ();

    mdss_spi_slave u_spi (
        .clk_i      (clk_i),
        .nrst_i     (nrst_i),
        .spi_sck_i  (spi_sck_i),
        .spi_mosi_i (spi_mosi_i),
        .spi_ss_n_i (spi_ss_n_i),
        .spi_miso_o (spi_miso_o),
        .wif        (wif)
    );

    ////////////////////////////////////////////////////////////////////////

    logic [mdss_pkg::SRC_BITS-1:0] src_ff;
    logic [2:0]                    spi_size_ff;
    logic                          spi_smooth_ff;
    logic                          spi_standstill_ff;
    logic                          spi_excite_ff;
    logic [RUN_W-1:0]              spi_run_ff;
    logic [2:0]                    size_ff;
    logic [11:0]                   rated_ff;
    logic                          alarm_ff;
    logic                          smooth_ff;
    logic                          standstill_ff;
    logic                          excite_ff;
    logic [RUN_W-1:0]              run_ff;
    mdss_pkg::mdss_state_e         state_ff;
    mdss_pkg::mdss_state_e         nxt_state;

    // Command decode
    // A word acts one clock after the slave raises valid
    wire [7:0] cmd  = wif.word[mdss_pkg::CMD_MSB:mdss_pkg::CMD_LSB];
    wire [7:0] data = wif.word[mdss_pkg::DAT_MSB:0];
    wire is_setting = wif.valid && cmd == mdss_pkg::CMD_SETTING;
    wire is_size    = wif.valid && cmd == mdss_pkg::CMD_FRAME_SIZE;
    wire is_smooth  = wif.valid && cmd == mdss_pkg::CMD_SMOOTH;
    wire is_still   = wif.valid && cmd == mdss_pkg::CMD_STANDSTILL;
    wire is_excite  = wif.valid && cmd == mdss_pkg::CMD_EXCITE;
    wire is_run     = wif.valid && cmd == mdss_pkg::CMD_OPERATING_CURRENT_COMMAND;
    wire is_apply   = wif.valid && cmd == mdss_pkg::CMD_APPLY;
    wire is_deact   = wif.valid && cmd == mdss_pkg::CMD_DEACTIVATE;
    wire is_clr     = wif.valid && cmd == mdss_pkg::CMD_ALARM_CLR;

    // Size source: pin code or last SPI code
    wire [2:0] pin_size = {size_sel_bit2_i, size_sel_bit1_i, size_sel_bit0_i};
    wire [2:0] sel_size = src_ff[mdss_pkg::SRC_FRAME] ? spi_size_ff
                                                      : pin_size;
    // Only codes from the table top down to its lowest entry are legal
    wire       size_ok  = sel_size >= mdss_pkg::SIZE_MIN;
    // Illegal codes index past the table end, but apply_ok masks them
    wire [2:0] size_idx = mdss_pkg::SIZE_TOP - sel_size;
    wire [11:0] rated_lut = five_phase_i ? mdss_pkg::RATED_5PH[size_idx]
                                         : mdss_pkg::RATED_2PH[size_idx];
    wire in_setting = state_ff == mdss_pkg::MDSS_SETTING;
    wire apply_ok   = is_apply && in_setting && size_ok;
    wire apply_bad  = is_apply && in_setting && !size_ok;

    // Live selections of the other four functions
    wire nxt_smooth = src_ff[mdss_pkg::SRC_SMOOTH] ? spi_smooth_ff
                                                   : smooth_drive_input_i;
    wire nxt_still  = src_ff[mdss_pkg::SRC_STANDSTILL]
                    ? spi_standstill_ff : standstill_current_input_i;
    wire excite_req = src_ff[mdss_pkg::SRC_EXCITE] ? spi_excite_ff
                                                   : ~enable_n_i;
    // Excitation is held off in the setting state and under an alarm
    wire nxt_excite = excite_req && !in_setting && !alarm_ff;
    wire [RUN_W-1:0] nxt_run = src_ff[mdss_pkg::SRC_RUN] ? spi_run_ff
                                                   : analog_current_input_i;

    ////////////////////////////////////////////////////////////////////////

    // Apply while operating is ignored; deactivate returns to setting
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            mdss_pkg::MDSS_SETTING: begin
                if (apply_ok) begin
                    nxt_state = mdss_pkg::MDSS_OPERATING;
                end
            end
            mdss_pkg::MDSS_OPERATING: begin
                if (is_deact) begin
                    nxt_state = mdss_pkg::MDSS_SETTING;
                end
            end
        endcase
    end

    // Host-written values; pins are ignored here while SPI is the source
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            src_ff            <= mdss_pkg::SRC_RESET;
            spi_size_ff       <= mdss_pkg::SIZE_RESET;
            spi_smooth_ff     <= mdss_pkg::SMOOTH_RESET;
            spi_standstill_ff <= mdss_pkg::STANDSTILL_RESET;
            spi_excite_ff     <= mdss_pkg::EXCITE_RESET;
            spi_run_ff        <= RUN_W'(mdss_pkg::RUN_RESET);
        end else begin
            if (is_setting) begin
                src_ff <= data[mdss_pkg::SRC_BITS-1:0];
            end
            if (is_size) begin
                spi_size_ff <= data[2:0];
            end
            if (is_smooth) begin
                spi_smooth_ff <= data[0];
            end
            if (is_still) begin
                spi_standstill_ff <= data[0];
            end
            if (is_excite) begin
                spi_excite_ff <= data[0];
            end
            if (is_run) begin
                spi_run_ff <= data[RUN_W-1:0];
            end
        end
    end

    // Size capture and state
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_ff <= mdss_pkg::MDSS_SETTING;
            size_ff  <= mdss_pkg::SIZE_RESET;
            rated_ff <= mdss_pkg::RATED_2PH[0];
        end else begin
            state_ff <= nxt_state;
            if (apply_ok) begin
                size_ff  <= sel_size;
                rated_ff <= rated_lut;
            end
        end
    end

    // Alarm: a new bad apply wins over a clear in the same cycle
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            alarm_ff <= 1'b0;
        end else if (apply_bad) begin
            alarm_ff <= 1'b1;
        end else if (is_clr) begin
            alarm_ff <= 1'b0;
        end
    end

    // Registered effective settings
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            smooth_ff     <= mdss_pkg::SMOOTH_RESET;
            standstill_ff <= mdss_pkg::STANDSTILL_RESET;
            excite_ff     <= 1'b0;
            run_ff        <= RUN_W'(mdss_pkg::RUN_RESET);
        end else begin
            smooth_ff     <= nxt_smooth;
            standstill_ff <= nxt_still;
            excite_ff     <= nxt_excite;
            run_ff        <= nxt_run;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    // Status word returned on the next SPI frame
    assign wif.status = {alarm_ff, !in_setting, excite_ff, smooth_ff,
                         standstill_ff, size_ff, 3'h0, src_ff};

    // Outputs come straight from flip-flops
    assign smooth_drive_o       = smooth_ff;
    assign standstill_half_o    = standstill_ff;
    assign excite_o             = excite_ff;
    assign operating_current_o  = run_ff;
    assign size_code_o          = size_ff;
    assign rated_current_ma_o   = rated_ff;
    assign operating_o          = !in_setting;
    assign cmd_disabled_alarm_o = alarm_ff;

endmodule
`default_nettype wire

// ==== mdss_pkg.sv ====
// Constants, command codes and tables of the setting-select block
//
// Overview of operation
// - Each of frame size, smooth drive, standstill current, excitation and operating current comes from its pin or from SPI, chosen by its own source bit.
// - After reset smooth drive, standstill current and operating current use SPI, while frame size and excitation use the pins.
// - The size code takes effect only when the apply command arrives over SPI while the block is in the setting state.
// - An untouched size setting reads as all bits high.
// - For a 2-phase motor the codes HHH, HHL, HLH, HLL, LHH, LHL give 0.5, 0.6, 1.5, 2.3, 2.3 and 2.8 A per phase.
// - For a 5-phase motor the same codes give 0.35, 0.75, 1.2, 1.4, 1.8 and 2.4 A per phase.
// - Applying any other size code in the setting state raises the command-execution-disabled alarm and the setting is not accepted.
// - With pin source, smooth drive is on while its pin is high and off while low.
// - The block is an SPI slave taking clock, data in and an active-low select, and returning data out.
`default_nettype none
package mdss_pkg;

    // SPI word layout
    localparam int          FRAME_BITS = 16;
    localparam int          CMD_MSB    = 15;
    localparam int          CMD_LSB    = 8;
    localparam int          DAT_MSB    = 7;

    // Command codes
    localparam logic [7:0]  CMD_SETTING    = 8'h01;
    localparam logic [7:0]  CMD_FRAME_SIZE = 8'h02;
    localparam logic [7:0]  CMD_SMOOTH     = 8'h03;
    localparam logic [7:0]  CMD_STANDSTILL = 8'h04;
    localparam logic [7:0]  CMD_EXCITE     = 8'h05;
    localparam logic [7:0]  CMD_OPERATING_CURRENT_COMMAND   = 8'h06;
    localparam logic [7:0]  CMD_APPLY      = 8'h10;
    localparam logic [7:0]  CMD_DEACTIVATE = 8'h11;
    localparam logic [7:0]  CMD_ALARM_CLR  = 8'h12;

    // Source field positions in the setting word, 0 = pin, 1 = SPI
    localparam int          SRC_FRAME      = 0;
    localparam int          SRC_SMOOTH     = 1;
    localparam int          SRC_STANDSTILL = 2;
    localparam int          SRC_EXCITE     = 3;
    localparam int          SRC_RUN        = 4;
    localparam int          SRC_BITS       = 5;
    localparam logic [4:0]  SRC_RESET      = 5'h16;

    // Reset values of the SPI-side settings
    localparam logic [2:0]  SIZE_RESET       = 3'h7;
    localparam logic        SMOOTH_RESET     = 1'b1;
    localparam logic        STANDSTILL_RESET = 1'b1;
    localparam logic        EXCITE_RESET     = 1'b0;
    localparam logic [7:0]  RUN_RESET        = 8'hFF;

    // Lowest legal size code; legal codes run from all-high downward
    localparam logic [2:0]  SIZE_MIN = 3'h2;
    localparam logic [2:0]  SIZE_TOP = 3'h7;
    localparam int          N_SIZES  = 6;

    // Rated current in mA, indexed by all-high code minus size code
    localparam logic [11:0] RATED_2PH [N_SIZES] = '{
        12'h1F4, 12'h258, 12'h5DC, 12'h8FC, 12'h8FC, 12'hAF0};
    localparam logic [11:0] RATED_5PH [N_SIZES] = '{
        12'h15E, 12'h2EE, 12'h4B0, 12'h578, 12'h708, 12'h960};

    typedef enum logic {
        MDSS_SETTING,
        MDSS_OPERATING
    } mdss_state_e;

endpackage
`default_nettype wire

// ==== mdss_word_if.sv ====
// Carrier of received SPI words and the status word sent back
`timescale 1ns/1ps
`default_nettype none
interface mdss_word_if;
    logic        valid;
    logic [15:0] word;
    logic [15:0] status;

    modport rx   (output valid, output word, input  status);
    modport core (input  valid, input  word, output status);
endinterface
`default_nettype wire

// ==== mdss_spi_slave.sv ====
// SPI slave: mode 0, MSB first, fixed 16-bit words
`timescale 1ns/1ps
`default_nettype none
module mdss_spi_slave (
    // Clock and reset
    input  wire logic   clk_i,
    input  wire logic   nrst_i,
    // SPI pins
    input  wire logic   spi_sck_i,
    input  wire logic   spi_mosi_i,
    input  wire logic   spi_ss_n_i,
    output logic        spi_miso_o,
    // Word side
    mdss_word_if.rx     wif
);

    logic        sck_ff;
    logic        ss_n_ff;
    logic [15:0] rx_ff;
    logic [15:0] tx_ff;
    logic [4:0]  cnt_ff;
    logic        valid_ff;
    logic        miso_ff;

    // Pins are synchronous to clk_i, so one stage suffices for edges
    wire rise      = spi_sck_i & ~sck_ff & ~spi_ss_n_i;
    wire fall      = ~spi_sck_i & sck_ff & ~spi_ss_n_i;
    wire sel_start = ~spi_ss_n_i & ss_n_ff;
    wire word_done = rise && (cnt_ff == 5'(mdss_pkg::FRAME_BITS - 1));
    wire [15:0] nxt_rx = {rx_ff[14:0], spi_mosi_i};

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sck_ff   <= 1'b0;
            ss_n_ff  <= 1'b1;
            rx_ff    <= 16'h0000;
            tx_ff    <= 16'h0000;
            cnt_ff   <= 5'h00;
            valid_ff <= 1'b0;
            miso_ff  <= 1'b0;
        end else begin
            sck_ff   <= spi_sck_i;
            ss_n_ff  <= spi_ss_n_i;
            valid_ff <= word_done;
            if (sel_start) begin
                // Status is frozen at select so the word cannot tear
                tx_ff   <= {wif.status[14:0], 1'b0};
                miso_ff <= wif.status[15];
                cnt_ff  <= 5'h00;
            end else if (rise) begin
                rx_ff  <= nxt_rx;
                cnt_ff <= word_done ? 5'h00 : cnt_ff + 5'h01;
            end else if (fall) begin
                miso_ff <= tx_ff[15];
                tx_ff   <= {tx_ff[14:0], 1'b0};
            end
            if (spi_ss_n_i) begin
                cnt_ff <= 5'h00;
            end
        end
    end

    assign wif.valid  = valid_ff;
    assign wif.word   = rx_ff;
    assign spi_miso_o = miso_ff;

endmodule
`default_nettype wire

// ==== mdss_setting_select_asserts.sv ====
// Port checker of the setting-select block
`timescale 1ns/1ps
`default_nettype none
module mdss_setting_select_asserts #(
    parameter int RUN_W = 8
) (
    // Clock and reset
    input wire logic             clk_i,
    input wire logic             nrst_i,
    // SPI pins
    input wire logic             spi_sck_i,
    input wire logic             spi_mosi_i,
    input wire logic             spi_ss_n_i,
    input wire logic             spi_miso_o,
    // Setting pins
    input wire logic             size_sel_bit0_i,
    input wire logic             size_sel_bit1_i,
    input wire logic             size_sel_bit2_i,
    input wire logic             smooth_drive_input_i,
    input wire logic             standstill_current_input_i,
    input wire logic             enable_n_i,
    input wire logic [RUN_W-1:0] analog_current_input_i,
    input wire logic             five_phase_i,
    // Effective settings and state
    input wire logic             smooth_drive_o,
    input wire logic             standstill_half_o,
    input wire logic             excite_o,
    input wire logic [RUN_W-1:0] operating_current_o,
    input wire logic [2:0]       size_code_o,
    input wire logic [11:0]      rated_current_ma_o,
    input wire logic             operating_o,
    input wire logic             cmd_disabled_alarm_o
);
    // Rated current in mA indexed by size code; codes 0 and 1 unused
    localparam logic [11:0] T2 [8] = '{12'h0, 12'h0, 12'hAF0, 12'h8FC,
        12'h8FC, 12'h5DC, 12'h258, 12'h1F4};
    localparam logic [11:0] T5 [8] = '{12'h0, 12'h0, 12'h960, 12'h708,
        12'h578, 12'h4B0, 12'h2EE, 12'h15E};
    wire logic [11:0] exp_ma = five_phase_i ? T5[size_code_o]
                                            : T2[size_code_o];

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    ////////////////////////////////////////////////////////////////////////
    rated_at_apply_a:
        assert property ($rose(operating_o) |-> rated_current_ma_o == exp_ma)
        else $error("rated current wrong after apply");
    size_legal_a:
        assert property (size_code_o >= 3'h2)
        else $error("size code outside table");
    size_on_apply_a:
        assert property ($changed(size_code_o) |-> $rose(operating_o))
        else $error("size code changed without apply");
    state_by_spi_a:
        assert property ($changed(operating_o) |-> !$past(spi_ss_n_i, 2))
        else $error("state changed without SPI word");
    alarm_no_accept_a:
        assert property ($rose(cmd_disabled_alarm_o) |->
            !operating_o && $stable(size_code_o))
        else $error("alarm raised but setting accepted");
    excite_gate_a:
        assert property (excite_o |->
            $past(operating_o) && !$past(cmd_disabled_alarm_o))
        else $error("excitation outside operating state");
    smooth_src_a:
        assert property ($changed(smooth_drive_o) |-> !$past(spi_ss_n_i, 3)
            || smooth_drive_o == $past(smooth_drive_input_i))
        else $error("smooth drive changed without cause");
    standstill_src_a:
        assert property ($changed(standstill_half_o) |-> !$past(spi_ss_n_i, 3)
            || standstill_half_o == $past(standstill_current_input_i))
        else $error("standstill rate changed without cause");

    apply_cov: cover property ($rose(operating_o));
    alarm_cov: cover property ($rose(cmd_disabled_alarm_o));
    excite_cov: cover property ($rose(excite_o));
endmodule
bind mdss_setting_select mdss_setting_select_asserts #(.RUN_W(RUN_W)) u_chk (.*);
`default_nettype wire

// ==== mdss_spi_host.sv ====
// SPI master model standing in for the host controller
`timescale 1ns/1ps
`default_nettype none
module mdss_spi_host (
    // Clock
    input  wire logic clk_i,
    // SPI pins
    output logic      sck_o,
    output logic      mosi_o,
    output logic      ss_n_o,
    input  wire logic miso_i
);
    initial begin
        sck_o = 1'b0;
        mosi_o = 1'b0;
        ss_n_o = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Three clocks a phase: the slave needs two to see each sck level
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        rx = 16'h0;
        @(posedge clk_i);
        ss_n_o <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi_o <= tx[i];
            repeat (3) @(posedge clk_i);
            sck_o <= 1'b1;
            rx = {rx[14:0], miso_i};
            repeat (3) @(posedge clk_i);
            sck_o <= 1'b0;
        end
        repeat (3) @(posedge clk_i);
        ss_n_o <= 1'b1;
        // A released data line must not keep showing its last bit
        mosi_o <= ~tx[0];
    endtask
endmodule
`default_nettype wire

// ==== mdss_setting_select_tb.sv ====
// Self-checking bench of the setting-select block
`timescale 1ns/1ps
`default_nettype none
module mdss_setting_select_tb;
    logic        clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        sck, mosi, ss_n, miso;
    logic [2:0]  size = 3'h7;
    logic        sd_pin = 1'b0;
    logic        ss_pin = 1'b0;
    logic        en_n = 1'b1;
    logic [7:0]  an = 8'h33;
    logic        five = 1'b0;
    logic        sd_o, half_o, exc_o, op_o, alm_o;
    logic [7:0]  run_o;
    logic [2:0]  code_o;
    logic [11:0] ma_o;
    logic [15:0] st;
    // Rated current in mA by phase count and size code; codes 0, 1 unused
    localparam logic [11:0] EXP_MA [2][8] = '{
        '{12'h000, 12'h000, 12'hAF0, 12'h8FC, 12'h8FC, 12'h5DC, 12'h258,
          12'h1F4},
        '{12'h000, 12'h000, 12'h960, 12'h708, 12'h578, 12'h4B0, 12'h2EE,
          12'h15E}};
    int          error_cnt = 0;
    int          comparisons = 0;
    int          cyc = 0;

    always #4 clk_i = ~clk_i;

    mdss_spi_host host (.clk_i(clk_i), .sck_o(sck), .mosi_o(mosi),
        .ss_n_o(ss_n), .miso_i(miso));
    mdss_setting_select #(.RUN_W(8)) DUT (.clk_i(clk_i), .nrst_i(nrst_i),
        .spi_sck_i(sck), .spi_mosi_i(mosi), .spi_ss_n_i(ss_n),
        .spi_miso_o(miso), .size_sel_bit0_i(size[0]),
        .size_sel_bit1_i(size[1]), .size_sel_bit2_i(size[2]),
        .smooth_drive_input_i(sd_pin), .standstill_current_input_i(ss_pin),
        .enable_n_i(en_n), .analog_current_input_i(an),
        .five_phase_i(five), .smooth_drive_o(sd_o),
        .standstill_half_o(half_o), .excite_o(exc_o),
        .operating_current_o(run_o), .size_code_o(code_o),
        .rated_current_ma_o(ma_o), .operating_o(op_o),
        .cmd_disabled_alarm_o(alm_o));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic hold;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] cmd, input logic [7:0] dat);
        host.xfer({cmd, dat}, st);
        hold();
    endtask
    task automatic end_of_test;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        hold();
        // Pins disagree with the SPI defaults, so these show the source
        chk({sd_o, half_o, run_o}, 10'h3FF);
        chk({op_o, alm_o, exc_o, code_o}, 6'h07);
        chk(ma_o, 12'h1F4);
        wr(8'h00, 8'h00);
        chk(st, 16'h1F16);
        wr(mdss_pkg::CMD_SMOOTH, 8'h00);
        wr(mdss_pkg::CMD_OPERATING_CURRENT_COMMAND, 8'h5A);
        @(posedge clk_i);
        sd_pin <= 1'b1;
        hold();
        chk({sd_o, run_o}, 9'h05A);
        wr(mdss_pkg::CMD_SETTING, 8'h00);
        chk({sd_o, half_o, run_o}, 10'h233);
        @(posedge clk_i);
        sd_pin <= 1'b0;
        ss_pin <= 1'b1;
        an <= 8'hC4;
        hold();
        chk({sd_o, half_o, run_o}, 10'h1C4);
        wr(mdss_pkg::CMD_SETTING, 8'h1F);
        chk({sd_o, half_o, run_o}, 10'h15A);
        wr(mdss_pkg::CMD_STANDSTILL, 8'h00);
        chk(half_o, 1'b0);
        wr(mdss_pkg::CMD_FRAME_SIZE, 8'h05);
        wr(mdss_pkg::CMD_APPLY, 8'h00);
        chk({op_o, code_o}, 4'hD);
        chk(ma_o, 12'h5DC);
        wr(mdss_pkg::CMD_EXCITE, 8'h01);
        chk(exc_o, 1'b1);
        wr(mdss_pkg::CMD_DEACTIVATE, 8'h00);
        wr(mdss_pkg::CMD_SETTING, 8'h00);
        for (int f = 0; f < 2; f++) begin
            for (int c = 7; c >= 2; c--) begin
                @(posedge clk_i);
                five <= f[0];
                size <= c[2:0];
                hold();
                wr(mdss_pkg::CMD_APPLY, 8'h00);
                chk({op_o, code_o}, {1'b1, c[2:0]});
                chk(ma_o, EXP_MA[f][c]);
                @(posedge clk_i);
                size <= ~c[2:0] | 3'h2;
                en_n <= 1'b0;
                hold();
                chk({exc_o, code_o}, {1'b1, c[2:0]});
                wr(mdss_pkg::CMD_APPLY, 8'h00);
                chk(code_o, c[2:0]);
                en_n <= 1'b1;
                wr(mdss_pkg::CMD_DEACTIVATE, 8'h00);
                chk({op_o, exc_o}, 2'h0);
            end
        end
        // Both codes below the table must be refused
        for (int c = 0; c < 2; c++) begin
            @(posedge clk_i);
            size <= c[2:0];
            hold();
            wr(mdss_pkg::CMD_APPLY, 8'h00);
            chk({alm_o, op_o, code_o}, 5'h12);
            wr(mdss_pkg::CMD_ALARM_CLR, 8'h00);
            chk(st, 16'h8A00);
            chk(alm_o, 1'b0);
        end
        // Reset in mid-run restores the power-up sources and values
        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        hold();
        chk({sd_o, half_o, run_o}, 10'h3FF);
        chk({op_o, alm_o, exc_o, code_o}, 6'h07);
        chk(ma_o, 12'h1F4);
        end_of_test();
    end
endmodule
`default_nettype wire
